// ---- hdl/ida_clock_divider.sv ----
`timescale 1ns/1ps
module ida_clock_divider #(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o,
  input  wire logic              align_pulse_i,
  output logic                   conv_clk_o,
  output logic                   sample_strobe_o,
  output logic                   duty_restorer_on_o
);
  localparam int CW = ida_pkg::DIV_RATIO_W;

  logic [DATA_W-1:0] div_ctrl;
  logic [DATA_W-1:0] align_ctrl;
  logic              armed;
  logic [CW-1:0]     cnt;
  logic [DATA_W-1:0] next_div_ctrl;
  logic [DATA_W-1:0] next_align_ctrl;
  logic              next_armed;
  logic [CW-1:0]     next_cnt;
  logic              next_conv_clk;
  logic              next_strobe;
  logic              next_duty_on;
  logic [DATA_W-1:0] next_rd_data;
  logic              sync_pulse;
  logic              wr_div;
  logic              wr_align;
  logic              accept;
  logic [CW-1:0]     ratio_m1;

  // address match against one register offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [12:0]       off);
    return a == ADDR_W'(off);
  endfunction

  // filtered alignment pin edge
  ida_pulse_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .pin_i     (align_pulse_i),
    .rise_o    (sync_pulse)
  );

  // write decode and pulse acceptance
  always_comb
  begin
    wr_div   = wr_en_i && addr_hit(wr_addr_i, ida_pkg::ADDR_CLOCK_DIVIDE);
    wr_align = wr_en_i && addr_hit(wr_addr_i, ida_pkg::ADDR_DIVIDER_ALIGN);
    ratio_m1 = div_ctrl[ida_pkg::DIV_RATIO_LSB +: CW];
    accept   = sync_pulse && align_ctrl[ida_pkg::ALIGN_EN_BIT]
               && (!align_ctrl[ida_pkg::ALIGN_FIRST_BIT] || armed);
  end

  // control registers and arming flag
  always_comb
  begin
    next_div_ctrl   = wr_div ? wr_data_i : div_ctrl;
    next_align_ctrl = wr_align ? wr_data_i : align_ctrl;
    next_armed      = armed;
    if (accept && align_ctrl[ida_pkg::ALIGN_FIRST_BIT])
      next_armed = 1'b0;
    if (wr_align)
      next_armed = 1'b1;
  end

  // divider counter and derived clock
  always_comb
  begin
    if (accept)
      next_cnt = '0;
    else if (cnt >= ratio_m1)
      next_cnt = '0;
    else
      next_cnt = cnt + CW'(1);
    next_strobe   = (next_cnt == '0);
    // only rises at count zero, so a ratio change cannot add an edge
    next_conv_clk = (next_cnt == '0)
                    || (conv_clk_o
                        && ({1'b0, next_cnt, 1'b0} < {2'b00, ratio_m1} + (CW + 2)'(1)));
    next_duty_on  = div_ctrl[ida_pkg::DUTY_EN_BIT] || (ratio_m1 != '0);
  end

  // read mux, one cycle latency
  always_comb
  begin
    next_rd_data = '0;
    if (addr_hit(rd_addr_i, ida_pkg::ADDR_CLOCK_DIVIDE))
      next_rd_data = div_ctrl;
    else if (addr_hit(rd_addr_i, ida_pkg::ADDR_DIVIDER_ALIGN))
    begin
      next_rd_data = align_ctrl;
      next_rd_data[ida_pkg::ALIGN_ARMED_BIT] = armed;
    end
  end

  // state registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_ctrl           <= ida_pkg::CLOCK_DIVIDE_RST;
      align_ctrl         <= ida_pkg::DIVIDER_ALIGN_RST;
      armed              <= 1'b0;
      cnt                <= '0;
      conv_clk_o         <= 1'b0;
      sample_strobe_o    <= 1'b0;
      duty_restorer_on_o <= 1'b0;
      rd_data_o          <= '0;
    end
    else
    begin
      div_ctrl           <= next_div_ctrl;
      align_ctrl         <= next_align_ctrl;
      armed              <= next_armed;
      cnt                <= next_cnt;
      conv_clk_o         <= next_conv_clk;
      sample_strobe_o    <= next_strobe;
      duty_restorer_on_o <= next_duty_on;
      rd_data_o          <= next_rd_data;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  // counter steps by one below the limit
  AST_COUNT_STEP: assert property (
    (!accept && cnt < ratio_m1) |=> cnt == $past(cnt) + CW'(1))
    else $error("divider count did not advance");

  // counter never passes a held ratio
  AST_COUNT_LIMIT: assert property (
    (!wr_en_i && $stable(div_ctrl)) ##1 (!wr_en_i) |-> cnt <= ratio_m1)
    else $error("divider count beyond ratio");

  // restorer forced above ratio 1
  AST_DUTY_FORCED: assert property (
    (ratio_m1 != '0) |=> duty_restorer_on_o)
    else $error("duty restorer not forced on");

  // alignment write arms the mode
  AST_ARM_ON_WRITE: assert property (
    wr_align |=> armed)
    else $error("alignment write did not arm");

  // accepted pulse restarts divider
  AST_REALIGN: assert property (
    accept |=> (cnt == '0) && sample_strobe_o && conv_clk_o)
    else $error("divider not realigned");

  // sample strobe marks rising edge
  AST_STROBE_EDGE: assert property (
    (ratio_m1 != '0 && $rose(conv_clk_o)) |-> sample_strobe_o)
    else $error("conversion clock rose without strobe");

  // disarmed stays disarmed without write
  AST_FIRST_ONLY: assert property (
    (!armed && !wr_align) |=> !armed)
    else $error("first-only mode re-armed itself");

  // disarmed pulses leave the count running in first-only mode
  AST_IGNORE_LATER: assert property (
    (align_ctrl[ida_pkg::ALIGN_FIRST_BIT] && !armed && sync_pulse)
    |=> (cnt == '0) == ($past(cnt) >= $past(ratio_m1)))
    else $error("pulse accepted while disarmed");

  // counter wraps at the limit
  AST_COUNT_WRAP: assert property (
    (!accept && cnt >= ratio_m1) |=> cnt == '0)
    else $error("divider count did not wrap");

  // ratio 1 leaves the restorer to its own bit
  AST_DUTY_FOLLOW: assert property (
    (ratio_m1 == '0) |=> duty_restorer_on_o == $past(div_ctrl[ida_pkg::DUTY_EN_BIT]))
    else $error("duty restorer does not follow its enable");

  // every-pulse mode takes each pulse
  AST_EVERY_PULSE: assert property (
    (sync_pulse && align_ctrl[ida_pkg::ALIGN_EN_BIT] && !align_ctrl[ida_pkg::ALIGN_FIRST_BIT])
    |=> cnt == '0)
    else $error("pulse not taken in every-pulse mode");

  // disabled alignment leaves the count running
  AST_DISABLED_IGNORE: assert property (
    (sync_pulse && !align_ctrl[ida_pkg::ALIGN_EN_BIT])
    |=> (cnt == '0) == ($past(cnt) >= $past(ratio_m1)))
    else $error("pulse taken while alignment disabled");

  // strobe only while the conversion clock is high
  AST_STROBE_HIGH: assert property (
    sample_strobe_o |-> conv_clk_o)
    else $error("strobe without conversion clock high");

  // armed state readable at bit zero
  AST_READ_ARMED: assert property (
    addr_hit(rd_addr_i, ida_pkg::ADDR_DIVIDER_ALIGN)
    |=> rd_data_o[ida_pkg::ALIGN_ARMED_BIT] == $past(armed))
    else $error("armed state not read back");

  // first accepted pulse disarms and realigns
  AST_FIRST_TAKEN: assert property (
    (armed && align_ctrl[ida_pkg::ALIGN_FIRST_BIT] && align_ctrl[ida_pkg::ALIGN_EN_BIT]
     && sync_pulse && !wr_align) |=> !armed && (cnt == '0))
    else $error("first pulse did not disarm");
endmodule

// ---- hdl/ida_pulse_sync.sv ----
`timescale 1ns/1ps
module ida_pulse_sync (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  output logic      rise_o
);
  logic [2:0] stage;
  logic       level;
  logic [2:0] next_stage;
  logic       next_level;
  logic       next_rise;

  // level changes only once stages two and three agree
  always_comb
  begin
    next_stage = {stage[1:0], pin_i};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
    next_rise  = next_level && !level;
  end

  // register the shift chain and the filtered edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage  <= 3'h0;
      level  <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      stage  <= next_stage;
      level  <= next_level;
      rise_o <= next_rise;
    end
  end
endmodule

// ---- shared/ida_pkg.sv ----
package ida_pkg;
  // register addresses
  localparam logic [12:0] ADDR_CLOCK_DIVIDE  = 13'h00b;
  localparam logic [12:0] ADDR_DIVIDER_ALIGN = 13'h100;
  // clock_divide fields
  localparam int          DIV_RATIO_LSB      = 0;
  localparam int          DIV_RATIO_W        = 3;
  localparam int          DUTY_EN_BIT        = 4;
  // divider_align_control fields
  localparam int          ALIGN_ARMED_BIT    = 0;
  localparam int          ALIGN_EN_BIT       = 1;
  localparam int          ALIGN_FIRST_BIT    = 2;
  // reset values
  localparam logic [7:0]  CLOCK_DIVIDE_RST   = 8'h00;
  localparam logic [7:0]  DIVIDER_ALIGN_RST  = 8'h00;
endpackage

// ---- tb/ida_sync_src.sv ----
`timescale 1ns/1ps
// alignment source: pin high 4 cycles per fire
module ida_sync_src (
  input  wire logic clk_sys_i,
  input  wire logic fire_i,
  output logic      align_o
);
  logic [2:0] hold = 3'h0;
  // width counter, pin low between pulses
  always @(posedge clk_sys_i)
  begin
    if (fire_i)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  assign align_o = (hold != 3'h0);
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        wr_en_i = 1'b0;
  logic [12:0] wr_addr_i = 13'h000;
  logic [7:0]  wr_data_i = 8'h00;
  logic [12:0] rd_addr_i = 13'h000;
  logic [7:0]  rd_data_o;
  logic        pin, conv_clk_o, sample_strobe_o, duty_restorer_on_o;
  logic        fire = 1'b0;
  logic        look = 1'b0;
  logic [8:0]  rd_q[$];
  logic [3:0]  gap_q[$];
  logic [3:0]  gap = 4'h0;
  logic [3:0]  hi = 4'h0;
  logic [3:0]  ratio = 4'h1;
  logic [31:0] seed = 32'h0000_1491;
  int          err_count = 0;
  int          samples_checked = 0;
  ida_clock_divider uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .align_pulse_i(pin), .conv_clk_o(conv_clk_o),
    .sample_strobe_o(sample_strobe_o), .duty_restorer_on_o(duty_restorer_on_o));
  ida_sync_src src (.clk_sys_i(clk_sys_i), .fire_i(fire), .align_o(pin));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_gap(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_en_i <= 1'b1;
    wr_addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, input logic [8:0] e);
    @(posedge clk_sys_i);
    rd_addr_i <= a;
    rd_q.push_back(e);
    @(posedge clk_sys_i);
    look <= 1'b1;
    @(posedge clk_sys_i);
    look <= 1'b0;
  endtask
  // fire one alignment pulse just after a strobe
  task automatic pulse(input logic [3:0] e);
    do @(negedge clk_sys_i); while (sample_strobe_o !== 1'b1);
    @(posedge clk_sys_i);
    fire <= 1'b1;
    gap_q.push_back(e);
    @(posedge clk_sys_i);
    fire <= 1'b0;
    repeat (24) @(posedge clk_sys_i);
  endtask
  task automatic report_and_stop();
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // monitor: retire notes, short gap reads as 0
  always @(negedge clk_sys_i)
  begin
    if (look)
      cmp({duty_restorer_on_o, rd_data_o}, rd_q.pop_front());
    if (sample_strobe_o === 1'b1)
    begin
      if (gap_q.size() > 0)
      begin
        if (gap == ratio)
          cmp_gap(hi, 4'((ratio + 4'h1) >> 1));
        cmp_gap((gap == ratio) ? gap : 4'h0, gap_q.pop_front());
      end
      cmp_gap({3'h0, conv_clk_o}, 4'h1);
      gap = 4'h1;
      hi = 4'h1;
    end
    else
    begin
      gap = gap + 4'h1;
      hi = hi + {3'h0, (conv_clk_o === 1'b1)};
    end
  end
  // clock
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // watchdog
  initial
  begin
    #50000;
    err_count++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(13'h00b, 9'h000);
    rd(13'h100, 9'h000);
    for (int r = 1; r <= 8; r++)
    begin
      seed = xs(seed);
      wr(13'h00b, {3'h0, seed[0], 1'b0, 3'(r - 1)});
      ratio = 4'(r);
      rd(13'h00b, {(r != 1) | seed[0], 3'h0, seed[0], 1'b0, 3'(r - 1)});
      repeat (20) @(posedge clk_sys_i);
      gap_q.push_back(4'(r));
      gap_q.push_back(4'(r));
      repeat (20) @(posedge clk_sys_i);
    end
    pulse(4'h8);
    wr(13'h100, 8'h02);
    pulse(4'h0);
    pulse(4'h0);
    wr(13'h100, 8'h06);
    rd(13'h100, 9'h107);
    pulse(4'h0);
    rd(13'h100, 9'h106);
    pulse(4'h8);
    wr(13'h100, 8'h06);
    pulse(4'h0);
    seed = xs(seed);
    wr(13'h055, seed[7:0]);
    rd(13'h055, 9'h100);
    report_and_stop();
  end
endmodule
